// File: pkg/dtcc_pkg.sv
// shared constants, enums and carrier structs for the dual-thread core control
package dtcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // structure
  localparam int NCORE = 2;
  localparam int NTHR = 2;
  localparam int PC_W = 64;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction word fields
  localparam int FLD_OP_HI = 31;
  localparam int FLD_OP_LO = 30;
  localparam int FLD_OP3_HI = 24;
  localparam int FLD_OP3_LO = 19;
  localparam int FLD_OPF_HI = 13;
  localparam int FLD_OPF_LO = 5;
  localparam int FLD_SIZE_HI = 6;
  localparam int FLD_SIZE_LO = 5;
  localparam logic [1:0] FMT_ARITH = 2'h2;
  localparam logic [5:0] OP3_POPULATION_COUNT_OP = 6'h2e;
  localparam logic [5:0] OP3_IMPDEP1 = 6'h36;
  localparam logic [5:0] OP3_IMPDEP2 = 6'h37;
  localparam logic [8:0] OPF_SUSPEND = 9'h082;
  localparam logic [8:0] OPF_SLEEP = 9'h083;
  localparam logic [1:0] FMA_SZ_SINGLE = 2'h1;
  localparam logic [1:0] FMA_SZ_DOUBLE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // debug instruction-trap match register location
  localparam logic [7:0] ASI_ITM = 8'h60;
  localparam logic [63:0] ITM_VA = 64'h0;
  localparam logic [31:0] ITM_RST = 32'h0;
  // arbitrary neutral serial value
  localparam logic [63:0] SERIAL_RST = 64'h0000_0000_0000_0001;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 125;
  localparam int QUANTUM_NS = 800;
  localparam int SLEEP_NS = 4000;
  localparam int QUANTUM_CYC = (QUANTUM_NS * CLK_MHZ) / 1000;
  localparam int SLEEP_CYC = (SLEEP_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] QUANTUM_LD = CNT_W'(QUANTUM_CYC - 1);
  localparam logic [CNT_W-1:0] SLEEP_LD = CNT_W'(SLEEP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // enums
  typedef enum logic [1:0] {
    TS_ACTIVE = 2'h0,
    TS_SLEEP = 2'h1,
    TS_SUSP = 2'h3
  } dtcc_tstate_e;

  typedef enum logic [2:0] {
    TK_NONE = 3'h0,
    TK_ILLEGAL = 3'h1,
    TK_FP_UNIMPL = 3'h2,
    TK_ASYNC_ERR = 3'h3,
    TK_INTERRUPT = 3'h4
  } dtcc_trap_e;

  typedef enum logic [2:0] {
    OP_OTHER = 3'h0,
    OP_FMA = 3'h1,
    OP_POPULATION_COUNT_OP = 3'h2,
    OP_SUSPEND = 3'h3,
    OP_SLEEP = 3'h4
  } dtcc_op_e;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic boundary;
    logic [31:0] inst;
    logic unimpl;
    logic unimpl_fp;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] npc;
    logic l2_miss;
  } dtcc_core_in_s;

  typedef struct packed {
    logic run_tid;
    logic sw_pulse;
    logic flush;
    logic resume_valid;
    logic [PC_W-1:0] resume_pc;
    logic [PC_W-1:0] resume_npc;
    dtcc_trap_e trap;
    dtcc_op_e op;
    dtcc_tstate_e [NTHR-1:0] tstate;
  } dtcc_core_out_s;

  typedef struct packed {
    logic cur;
    logic [CNT_W-1:0] qcnt;
    logic [NTHR-1:0][CNT_W-1:0] scnt;
    dtcc_tstate_e [NTHR-1:0] ts;
    logic [NTHR-1:0] err;
    logic rd_pend;
    dtcc_core_out_s out;
  } dtcc_core_st_s;

  typedef struct packed {
    dtcc_core_st_s [NCORE-1:0] core;
    logic [31:0] itm;
    logic [63:0] l2diag;
    logic [63:0] serial;
  } dtcc_state_s;

endpackage

// File: tb/dtcc_ctrl_checker.sv
// assertions on the dual-thread core control ports
`timescale 1ns/100ps
module dtcc_ctrl_checker
  import dtcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire dtcc_core_in_s [NCORE-1:0] core_in,
  input wire logic [NCORE*NTHR-1:0] irq,
  input wire logic async_err,
  input wire logic [NCORE*NTHR-1:0] async_err_mask,
  input wire logic debug_en,
  input wire dtcc_core_out_s [NCORE-1:0] core_out,
  input wire logic [63:0] module_serial_number
);
  logic err_q;
  logic quiet;
  dtcc_core_in_s ci;
  dtcc_core_out_s co;

  // a pending error may trap later, so trap relations stop once one is seen
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      err_q <= 1'b0;
    else if (async_err)
      err_q <= 1'b1;

  // core 0 only: core 1 is the same logic
  assign ci = core_in[0];
  assign co = core_out[0];
  assign quiet = ci.boundary & !async_err & !err_q & !debug_en & (irq[1:0] == 2'h0);

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////
  chk_flush_pair: assert property (co.sw_pulse |-> co.flush)
    else $error("switch without flush");
  chk_tid_flip: assert property (co.sw_pulse |-> co.run_tid != $past(co.run_tid))
    else $error("switch left running thread unchanged");
  chk_resume_next: assert property (co.sw_pulse |=> co.resume_valid)
    else $error("no resume after switch");
  chk_trap_holds: assert property (co.trap != TK_NONE |-> !co.sw_pulse)
    else $error("switch taken with a trap");
  chk_l2_switch: assert property (quiet && ci.l2_miss && ci.inst == 32'h0
    && !ci.unimpl && co.tstate == '0 |=> co.sw_pulse)
    else $error("l2 miss did not switch");
  chk_illegal_trap: assert property (quiet && ci.unimpl && !ci.unimpl_fp
    |=> co.trap == TK_ILLEGAL)
    else $error("unimplemented op without illegal trap");
  chk_fp_trap: assert property (quiet && ci.unimpl && ci.unimpl_fp
    |=> co.trap == TK_FP_UNIMPL)
    else $error("unimplemented fp op without fp trap");
  chk_population_count_op_op: assert property (quiet && !ci.unimpl && ci.inst[31:30] == FMT_ARITH
    && ci.inst[24:19] == OP3_POPULATION_COUNT_OP |=> co.op == OP_POPULATION_COUNT_OP)
    else $error("population_count_op not decoded");
  // the error is captured first, so it traps at the following boundary
  chk_async_run: assert property ((async_err && async_err_mask[0]) ##1
    (ci.boundary && co.run_tid == 1'b0) |=> co.trap == TK_ASYNC_ERR)
    else $error("async error not reported");
  chk_serial_fixed: assert property (module_serial_number == SERIAL_RST)
    else $error("serial register changed");
endmodule

// File: tb/testbench.sv
// self-checking bench for the dual-thread core control
`timescale 1ns/100ps
module testbench
  import dtcc_pkg::*;
;
  typedef struct packed {dtcc_trap_e trap; dtcc_op_e op;} dtcc_note_s;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  dtcc_core_in_s [NCORE-1:0] core_in = '0;
  logic [3:0] irq = '0;
  logic [3:0] async_err_mask = '0;
  logic async_err = 1'b0;
  logic asi_wr = 1'b0;
  logic debug_en = 1'b0;
  logic l2diag_load = 1'b0;
  logic [7:0] asi_wr_asi = '0;
  logic [63:0] asi_wr_va = '0;
  logic [31:0] asi_wr_data = '0;
  logic [63:0] l2diag_data = '0;
  logic [63:0] l2_tag_diag_read;
  logic [63:0] module_serial_number;
  dtcc_core_out_s [NCORE-1:0] core_out;
  dtcc_note_s q_op[$];
  logic q_sw[$];
  dtcc_note_s m;
  int fail_count = 0;
  int total_checks = 0;

  initial
    forever #4 clk_sys = ~clk_sys;

  dtcc_ctrl uut (.clk_sys(clk_sys), .rst_b(rst_b), .core_in(core_in), .irq(irq),
    .async_err(async_err), .async_err_mask(async_err_mask), .asi_wr(asi_wr),
    .asi_wr_asi(asi_wr_asi), .asi_wr_va(asi_wr_va), .asi_wr_data(asi_wr_data),
    .debug_en(debug_en), .l2diag_load(l2diag_load), .l2diag_data(l2diag_data),
    .core_out(core_out), .l2_tag_diag_read(l2_tag_diag_read),
    .module_serial_number(module_serial_number));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (exp !== got)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // every note must be used up before the next reset
  task automatic reset_dut;
    check("notes left", 64'h0, 64'(q_op.size() + q_sw.size()));
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
  endtask

  // one boundary on core 0; the pc pair is the outgoing thread's
  task automatic bnd(input logic [31:0] inst, input logic [1:0] un, input logic l2,
    input logic err, input logic [63:0] pc);
    @(posedge clk_sys);
    core_in[0] <= '{1'b1, inst, un[1], un[0], pc, pc + 64'h4, l2};
    async_err <= err;
    @(posedge clk_sys);
    core_in[0].boundary <= 1'b0;
    async_err <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic asi_write(input logic [7:0] s, input logic [63:0] va, input logic [31:0] d);
    @(posedge clk_sys);
    asi_wr <= 1'b1;
    asi_wr_asi <= s;
    asi_wr_va <= va;
    asi_wr_data <= d;
    @(posedge clk_sys);
    asi_wr <= 1'b0;
  endtask

  ////////////////////////////////////////
  // results may land in separate cycles, so trap/op and switches queue apart
  always @(posedge clk_sys)
  begin
    #1;
    if (core_out[0].trap !== TK_NONE || core_out[0].op !== OP_OTHER)
    begin
      if (q_op.size() == 0)
        check("unexpected trap or op", 64'h0, 64'h1);
      else
      begin
        m = q_op.pop_front();
        check("trap", m.trap, core_out[0].trap);
        if (m.trap == TK_NONE)
          check("op", m.op, core_out[0].op);
      end
    end
    if (core_out[0].sw_pulse !== 1'b0)
    begin
      if (q_sw.size() == 0)
        check("unexpected switch", 64'h0, 64'h1);
      else
        check("run thread", q_sw.pop_front(), core_out[0].run_tid);
    end
  end

  initial
  begin
    logic [63:0] a;
    logic [31:0] w;
    dtcc_note_s n;
    a = 64'($urandom(32'h6b47cef5));
    reset_dut;
    check("serial", SERIAL_RST, module_serial_number);
    a = {$urandom, $urandom};
    l2diag_data <= a;
    l2diag_load <= 1'b1;
    @(posedge clk_sys);
    l2diag_load <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("l2 diag", a, l2_tag_diag_read);
    // population_count_op, fma single and double with random variation, quad size traps
    for (int i = 0; i < 4; i++)
    begin
      w = {FMT_ARITH, 5'h0, (i == 0) ? OP3_POPULATION_COUNT_OP : OP3_IMPDEP2,
        (i == 0) ? 12'h0 : 12'($urandom), 2'(i), 5'h3};
      n.trap = (i == 3) ? TK_FP_UNIMPL : TK_NONE;
      n.op = (i == 0) ? OP_POPULATION_COUNT_OP : OP_FMA;
      q_op.push_back(n);
      bnd(w, 2'h0, 1'b0, 1'b0, 64'h0);
    end
    for (int i = 2; i < 4; i++)
    begin
      n.trap = (i == 2) ? TK_ILLEGAL : TK_FP_UNIMPL;
      q_op.push_back(n);
      bnd(32'h0, 2'(i), 1'b0, 1'b0, 64'h0);
    end
    // match register: wrong space or offset must not overwrite it
    reset_dut;
    w = {2'h0, 30'($urandom)};
    asi_write(ASI_ITM, ITM_VA, ~w);
    asi_write(8'h61, ITM_VA, w);
    asi_write(ASI_ITM, 64'h8, w);
    debug_en <= 1'b1;
    n.trap = TK_ILLEGAL;
    q_op.push_back(n);
    bnd(~w, 2'h0, 1'b0, 1'b0, 64'h0);
    check("match trap taken", 64'h0, 64'(q_op.size()));
    bnd(w, 2'h0, 1'b0, 1'b0, 64'h0);
    debug_en <= 1'b0;
    // l2 miss switches there and back, then the quantum runs out
    reset_dut;
    a = {$urandom, $urandom};
    q_sw.push_back(1'b1);
    bnd(32'h0, 2'h0, 1'b1, 1'b0, a);
    check("core 1 thread", 64'h0, core_out[1].run_tid);
    // core 1 switches on its own miss and leaves core 0 alone
    @(posedge clk_sys);
    core_in[1] <= '{1'b1, 32'h0, 1'b0, 1'b0, a, a + 64'h4, 1'b1};
    @(posedge clk_sys);
    core_in[1].boundary <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("core 1 switch", 64'h1, core_out[1].run_tid);
    check("core 0 kept", 64'h1, core_out[0].run_tid);
    q_sw.push_back(1'b0);
    bnd(32'h0, 2'h0, 1'b1, 1'b0, ~a);
    check("resume pc", a, core_out[0].resume_pc);
    check("resume npc", a + 64'h4, core_out[0].resume_npc);
    repeat (QUANTUM_CYC) @(posedge clk_sys);
    q_sw.push_back(1'b1);
    bnd(32'h0, 2'h0, 1'b0, 1'b0, 64'h0);
    // suspend thread 0, sleep thread 1, irq wakes thread 0
    reset_dut;
    n = '{TK_NONE, OP_SUSPEND};
    q_op.push_back(n);
    q_sw.push_back(1'b1);
    bnd({FMT_ARITH, 5'h0, OP3_IMPDEP1, 5'h0, OPF_SUSPEND, 5'h0}, 2'h0, 1'b0, 1'b0, 64'h0);
    check("suspended", TS_SUSP, core_out[0].tstate[0]);
    n.op = OP_SLEEP;
    q_op.push_back(n);
    bnd({FMT_ARITH, 5'h0, OP3_IMPDEP1, 5'h0, OPF_SLEEP, 5'h0}, 2'h0, 1'b0, 1'b0, 64'h0);
    repeat (SLEEP_CYC - 20) @(posedge clk_sys);
    check("asleep", TS_SLEEP, core_out[0].tstate[1]);
    repeat (40) @(posedge clk_sys);
    check("awake", TS_ACTIVE, core_out[0].tstate[1]);
    irq <= 4'h1;
    q_sw.push_back(1'b0);
    bnd(32'h0, 2'h0, 1'b0, 1'b0, 64'h0);
    irq <= 4'h0;
    check("woken", TS_ACTIVE, core_out[0].tstate[0]);
    // one error for every thread, reported to core 0's threads in turn
    reset_dut;
    async_err_mask <= 4'hf;
    async_err <= 1'b1;
    n.trap = TK_ASYNC_ERR;
    q_op.push_back(n);
    bnd({FMT_ARITH, 5'h0, OP3_POPULATION_COUNT_OP, 19'h0}, 2'h0, 1'b0, 1'b0, 64'h0);
    q_sw.push_back(1'b1);
    bnd(32'h0, 2'h0, 1'b1, 1'b0, 64'h0);
    q_op.push_back(n);
    bnd(32'h0, 2'h0, 1'b0, 1'b0, 64'h0);
    reset_dut;
    summarize;
  end
endmodule

bind dtcc_ctrl dtcc_ctrl_checker chk (.clk_sys(clk_sys), .rst_b(rst_b), .core_in(core_in),
  .irq(irq), .async_err(async_err), .async_err_mask(async_err_mask), .debug_en(debug_en),
  .core_out(core_out), .module_serial_number(module_serial_number));

// File: verilog/dtcc_ctrl.sv
// thread-context control for two cores with two interleaved threads each
`timescale 1ns/100ps
// Function
// - two cores, two full contexts each
// - one thread runs per core, alternating
// - interrupt for waiting thread forces switch
// - switch on l2 miss and timer expiry
// - suspend and sleep instructions halt thread
// - both threads share translation buffers
// - cores share only l2 and system interface
// - async errors reach every related thread
// - l2 diag and serial registers single instance
// - unimplemented ops trap illegal or fp unimpl
// - debug match register raises illegal trap
// - listed traps are never raised
// - errors and interrupts arise on any opcode
// - decode fma, population_count_op, suspend, sleep
module dtcc_ctrl
  import dtcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire dtcc_core_in_s [NCORE-1:0] core_in,
  input wire logic [NCORE*NTHR-1:0] irq,
  input wire logic async_err,
  input wire logic [NCORE*NTHR-1:0] async_err_mask,
  input wire logic asi_wr,
  input wire logic [7:0] asi_wr_asi,
  input wire logic [63:0] asi_wr_va,
  input wire logic [31:0] asi_wr_data,
  input wire logic debug_en,
  input wire logic l2diag_load,
  input wire logic [63:0] l2diag_data,
  output dtcc_core_out_s [NCORE-1:0] core_out,
  output logic [63:0] l2_tag_diag_read,
  output logic [63:0] module_serial_number
);

  dtcc_state_s state_q;
  dtcc_state_s state_d;
  logic [NCORE-1:0] mem_we;
  logic [NCORE-1:0] mem_waddr;
  logic [NCORE-1:0][2*PC_W-1:0] mem_wdata;
  logic [NCORE-1:0] mem_re;
  logic [NCORE-1:0] mem_raddr;
  logic [NCORE-1:0][2*PC_W-1:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // saved pc/npc store, private to each core
  genvar gc;
  generate
    for (gc = 0; gc < NCORE; gc++)
    begin : g_core
      dtcc_ctx_mem u_ctx (
        .clk_sys(clk_sys),
        .we(mem_we[gc]),
        .waddr(mem_waddr[gc]),
        .wdata(mem_wdata[gc]),
        .re(mem_re[gc]),
        .raddr(mem_raddr[gc]),
        .rdata(mem_rdata[gc])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // decode of implementation-specific operations
  function automatic dtcc_op_e dec_op(input logic [31:0] w);
    logic [1:0] fmt;
    logic [5:0] op3;
    logic [8:0] opf;
    logic [1:0] sz;
    fmt = w[FLD_OP_HI:FLD_OP_LO];
    op3 = w[FLD_OP3_HI:FLD_OP3_LO];
    opf = w[FLD_OPF_HI:FLD_OPF_LO];
    sz = w[FLD_SIZE_HI:FLD_SIZE_LO];
    dec_op = OP_OTHER;
    if (fmt == FMT_ARITH)
    begin
      case (op3)
        OP3_POPULATION_COUNT_OP: dec_op = OP_POPULATION_COUNT_OP;
        OP3_IMPDEP1:
        begin
          // reserved fields are trusted to be zero; no check is made
          if (opf == OPF_SUSPEND)
            dec_op = OP_SUSPEND;
          else if (opf == OPF_SLEEP)
            dec_op = OP_SLEEP;
        end
        OP3_IMPDEP2:
        begin
          if (sz == FMA_SZ_SINGLE || sz == FMA_SZ_DOUBLE)
            dec_op = OP_FMA;
        end
        default: dec_op = OP_OTHER;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic for both cores and the module-wide registers
  always_comb
  begin
    logic cur;
    logic oth;
    logic want_sw;
    logic [31:0] w;
    dtcc_op_e op;
    dtcc_trap_e trap;
    cur = 1'b0;
    oth = 1'b0;
    want_sw = 1'b0;
    w = 32'h0;
    op = OP_OTHER;
    trap = TK_NONE;
    state_d = state_q;
    mem_we = '0;
    mem_waddr = '0;
    mem_wdata = '0;
    mem_re = '0;
    mem_raddr = '0;

    // single module-wide copies seen by every thread
    if (asi_wr && asi_wr_asi == ASI_ITM && asi_wr_va == ITM_VA)
      state_d.itm = asi_wr_data;
    if (l2diag_load)
      state_d.l2diag = l2diag_data;

    for (int c = 0; c < NCORE; c++)
    begin
      cur = state_q.core[c].cur;
      oth = ~cur;
      w = core_in[c].inst;
      // pulses last one cycle
      state_d.core[c].out.sw_pulse = 1'b0;
      state_d.core[c].out.flush = 1'b0;
      state_d.core[c].out.resume_valid = 1'b0;
      state_d.core[c].out.trap = TK_NONE;
      state_d.core[c].out.op = OP_OTHER;

      // quantum timer, an invisible throughput trigger
      if (state_q.core[c].qcnt != '0)
        state_d.core[c].qcnt = state_q.core[c].qcnt - CNT_W'(1);

      // wake halted threads; sleep also ends on its own timeout
      for (int t = 0; t < NTHR; t++)
      begin
        case (state_q.core[c].ts[t])
          TS_SLEEP:
          begin
            if (state_q.core[c].scnt[t] != '0)
              state_d.core[c].scnt[t] = state_q.core[c].scnt[t] - CNT_W'(1);
            if (irq[2*c+t] || state_q.core[c].scnt[t] == '0)
              state_d.core[c].ts[t] = TS_ACTIVE;
          end
          TS_SUSP:
          begin
            if (irq[2*c+t])
              state_d.core[c].ts[t] = TS_ACTIVE;
          end
          default: state_d.core[c].ts[t] = state_q.core[c].ts[t];
        endcase
        // error capture; a new error beats a clear in the same cycle
        if (async_err && async_err_mask[2*c+t])
          state_d.core[c].err[t] = 1'b1;
      end

      if (core_in[c].boundary)
      begin
        op = dec_op(w);
        trap = TK_NONE;
        // error and interrupt checks ignore the opcode entirely
        if (state_q.core[c].err[cur])
          trap = TK_ASYNC_ERR;
        else if (irq[2*c+cur])
          trap = TK_INTERRUPT;
        else if (debug_en && w == state_q.itm)
          trap = TK_ILLEGAL;
        else if (core_in[c].unimpl)
          trap = core_in[c].unimpl_fp ? TK_FP_UNIMPL : TK_ILLEGAL;
        else if (w[FLD_OP_HI:FLD_OP_LO] == FMT_ARITH &&
                 w[FLD_OP3_HI:FLD_OP3_LO] == OP3_IMPDEP2 && op != OP_FMA)
          trap = TK_FP_UNIMPL;
        // the trap set holds no mmu-miss, protection, ldd/std, quad-align,
        // internal-error or invalid-register kinds
        state_d.core[c].out.trap = trap;
        state_d.core[c].out.op = op;
        if (trap == TK_ASYNC_ERR && !(async_err && async_err_mask[2*c+cur]))
          state_d.core[c].err[cur] = 1'b0;

        if (trap == TK_NONE && op == OP_SUSPEND)
          state_d.core[c].ts[cur] = TS_SUSP;
        if (trap == TK_NONE && op == OP_SLEEP)
        begin
          state_d.core[c].ts[cur] = TS_SLEEP;
          state_d.core[c].scnt[cur] = SLEEP_LD;
        end

        want_sw = irq[2*c+oth] ||
                  (state_q.core[c].ts[oth] == TS_ACTIVE &&
                   (core_in[c].l2_miss || state_q.core[c].qcnt == '0 ||
                    op == OP_SUSPEND || op == OP_SLEEP));
        want_sw = want_sw && trap == TK_NONE;
      end
      else
      begin
        // halted thread has nothing in flight, so no boundary is needed
        want_sw = state_q.core[c].ts[cur] != TS_ACTIVE &&
                  (state_q.core[c].ts[oth] == TS_ACTIVE || irq[2*c+oth]);
      end

      // switch: park outgoing pc pair only at a boundary, fetch incoming pair
      if (want_sw)
      begin
        state_d.core[c].cur = oth;
        state_d.core[c].out.sw_pulse = 1'b1;
        state_d.core[c].out.flush = 1'b1;
        state_d.core[c].qcnt = QUANTUM_LD;
        state_d.core[c].rd_pend = 1'b1;
        state_d.core[c].ts[oth] = TS_ACTIVE;
        mem_we[c] = core_in[c].boundary;
        mem_waddr[c] = cur;
        mem_wdata[c] = {core_in[c].pc, core_in[c].npc};
        mem_re[c] = 1'b1;
        mem_raddr[c] = oth;
      end
      else
      begin
        state_d.core[c].rd_pend = 1'b0;
      end

      // incoming thread resumes from its saved pair
      if (state_q.core[c].rd_pend)
      begin
        state_d.core[c].out.resume_valid = 1'b1;
        state_d.core[c].out.resume_pc = mem_rdata[c][2*PC_W-1:PC_W];
        state_d.core[c].out.resume_npc = mem_rdata[c][PC_W-1:0];
      end
      state_d.core[c].out.run_tid = state_d.core[c].cur;
      state_d.core[c].out.tstate = state_d.core[c].ts;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= '0;
      for (int c = 0; c < NCORE; c++)
      begin
        state_q.core[c].qcnt <= QUANTUM_LD;
      end
      state_q.itm <= ITM_RST;
      state_q.serial <= SERIAL_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  // translation buffers live outside; one per core is shared by both threads
  for (gc = 0; gc < NCORE; gc++)
  begin : g_out
    assign core_out[gc] = state_q.core[gc].out;
  end
  assign l2_tag_diag_read = state_q.l2diag;
  assign module_serial_number = state_q.serial;

endmodule

// File: verilog/dtcc_ctx_mem.sv
// two-entry saved program counter store for one core, registered read
`timescale 1ns/100ps
module dtcc_ctx_mem
  import dtcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic we,
  input wire logic waddr,
  input wire logic [2*PC_W-1:0] wdata,
  input wire logic re,
  input wire logic raddr,
  output logic [2*PC_W-1:0] rdata
);

  logic [2*PC_W-1:0] mem [NTHR];

  // storage holds no reset value; the first switch after reset reads an entry never written
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule
